// >>> rtl/ccm_clock_control.sv
// codec clock mux and pll control: reference select, doublers, predivider,
// pll settings with paged fractional/post-divider word, clock dividers
// assumes clock pins are sampled at the core clock, well above their rate
//
// Notes on behaviour
// - ref select bit 0 picks first reference (0) or second (1)
// - bits 1 and 2 enable doublers on first and second inputs, reset off
// - predivider: bit 9 off divides by 1, on divides by 2 or 4 per bit 8
// - bit 11 adds divide by 4 in pll feedback for slow inputs
// - bits 15:12 pll divisor; codes 0 and 1 divide by 1
// - bit 10 clear gives integer mode, set enables sigma-delta
// - pll output divided by 4 forms the system clock when source bit 7 is clear
// - fractional word is 22 bits, computed by software
// - page field 6:4 picks one of 8 slots, nibble 3:0 is stored
// - pages 7,6 post-divider; page 5 top frac bits; 4..0 lower nibbles
// - pll clock in use means post-divider comes from the paged word
// - internal clock off bit 13 set stops internal clocks, reset set
// - pll off bit 9 set keeps pll down; reset set
// - link bit clock derives from the system clock, from the pll or the external path
// - source bit 7 clear picks pll, set picks external; reset external
// - external mode hi-fi divides 1 to 8, voice 1 to 16, reset by 1
// - link bit clock is system clock divided by 2
`timescale 1ns/1ps
module ccm_clock_control
   import ccm_pkg::*;
(
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RESETN_IN,
   input  wire logic        CLK_EN_IN,
   input  wire logic        FIRST_REF_CLOCK_IN,
   input  wire logic        SECOND_REF_CLOCK_IN,
   input  wire logic        PLL_OUT_CLOCK_IN,
   input  wire logic        REG_WR_IN,
   input  wire logic        REG_RD_IN,
   input  wire logic [6:0]  REG_ADDR_IN,
   input  wire logic [15:0] REG_WDATA_IN,
   output logic [15:0]      REG_RDATA_OUT,
   output logic             REG_RVALID_OUT,
   output logic             SYSTEM_CLOCK_OUT,
   output logic             BIT_CLOCK_OUT,
   output logic             HIFI_CLOCK_OUT,
   output logic             VOICE_CLOCK_OUT,
   output logic             PLL_REF_CLOCK_OUT,
   output logic [2:0]       PLL_PREDIV_OUT,
   output logic [3:0]       PLL_N_DIV_OUT,
   output logic [5:0]       PLL_FB_DIV_OUT,
   output logic             PLL_LOW_RANGE_OUT,
   output logic             PLL_SDM_EN_OUT,
   output logic [21:0]      PLL_FRAC_OUT,
   output logic             PLL_POWER_DOWN_OUT,
   output logic             INT_CLOCKS_ON_OUT
);

   typedef struct packed {
      logic [2:0]      sync1;
      logic [2:0]      sync2;
      logic [1:0]      sync3;
      logic            ref_select;
      logic            first_dbl;
      logic            second_dbl;
      logic            src_ext;
      logic [6:0]      post_ext;
      logic [3:0]      n_code;
      logic            low_range;
      logic            sdm_en;
      logic            prediv_en;
      logic            prediv_val;
      logic [2:0]      page;
      logic [7:0][3:0] slot;
      logic            clk_off;
      logic            pll_off;
      ccm_sw_t         sw;
      logic            cur_sel;
      logic            ref_out;
      logic            sys_out;
      logic [15:0]     rdata;
      logic            rvalid;
   } ccm_state_t;

   ccm_state_t st_ff;
   ccm_state_t nxt_st;

   logic       ref_first;
   logic       ref_second;
   logic       ref_cur;
   logic       pll_quarter;
   logic [6:0] post_word;
   logic [4:0] prediv_ratio;
   logic [4:0] hifi_ratio;
   logic [4:0] voice_ratio;
   logic       wr_mux;
   logic       wr_pll;

   // doubler: one sample-wide pulse per edge doubles the rate
   assign ref_first  = st_ff.first_dbl ? (st_ff.sync2[0] ^ st_ff.sync3[0])
                                       : st_ff.sync2[0];
   assign ref_second = st_ff.second_dbl ? (st_ff.sync2[1] ^ st_ff.sync3[1])
                                        : st_ff.sync2[1];
   assign ref_cur    = st_ff.cur_sel ? ref_second : ref_first;

   assign prediv_ratio = !st_ff.prediv_en ? PREDIV_OFF :
                         (st_ff.prediv_val ? PREDIV_QUARTER : PREDIV_HALF);
   assign post_word    = st_ff.src_ext ? st_ff.post_ext
                         : {st_ff.slot[PAGE_POST_HI][2:0],
                            st_ff.slot[PAGE_POST_LO]};
   assign hifi_ratio   = ccm_ratio({1'h0, post_word[6:4]});
   assign voice_ratio  = ccm_ratio(post_word[3:0]);

   assign wr_mux = REG_WR_IN && (REG_ADDR_IN == CLOCK_MUX_AND_DIVIDER_ADDR);
   assign wr_pll = REG_WR_IN && (REG_ADDR_IN == PLL_CONFIG_AND_PAGER_ADDR);

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.sync1 = {PLL_OUT_CLOCK_IN, SECOND_REF_CLOCK_IN,
                      FIRST_REF_CLOCK_IN};
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.sync3 = st_ff.sync2[1:0];

      if (wr_mux) begin
         nxt_st.ref_select = REG_WDATA_IN[REF_SELECT_BIT];
         nxt_st.first_dbl  = REG_WDATA_IN[FIRST_DBL_BIT];
         nxt_st.second_dbl = REG_WDATA_IN[SECOND_DBL_BIT];
         nxt_st.src_ext    = REG_WDATA_IN[SOURCE_SEL_BIT];
         nxt_st.post_ext   = REG_WDATA_IN[POST_DIV_LSB +: POST_DIV_W];
      end
      if (wr_pll) begin
         nxt_st.n_code     = REG_WDATA_IN[N_CODE_LSB +: 4];
         nxt_st.low_range  = REG_WDATA_IN[LOW_RANGE_BIT];
         nxt_st.sdm_en     = REG_WDATA_IN[SIGMA_DELTA_BIT];
         nxt_st.prediv_en  = REG_WDATA_IN[PREDIV_EN_BIT];
         nxt_st.prediv_val = REG_WDATA_IN[PREDIV_VAL_BIT];
         nxt_st.page       = REG_WDATA_IN[PAGE_SEL_LSB +: 3];
         // only the addressed slot moves; reserved bits are not kept
         unique case (REG_WDATA_IN[PAGE_SEL_LSB +: 3])
            PAGE_POST_HI: nxt_st.slot[PAGE_POST_HI] =
               REG_WDATA_IN[PAGE_NIBBLE_LSB +: 4] & POST_HI_MASK;
            PAGE_FRAC_TOP: nxt_st.slot[PAGE_FRAC_TOP] =
               REG_WDATA_IN[PAGE_NIBBLE_LSB +: 4] & FRAC_TOP_MASK;
            default: nxt_st.slot[REG_WDATA_IN[PAGE_SEL_LSB +: 3]] =
               REG_WDATA_IN[PAGE_NIBBLE_LSB +: 4];
         endcase
      end
      if (REG_WR_IN && (REG_ADDR_IN == POWER_CLOCK_ADDR)) begin
         nxt_st.clk_off = REG_WDATA_IN[CLOCK_OFF_BIT];
      end
      if (REG_WR_IN && (REG_ADDR_IN == POWER_PLL_ADDR)) begin
         nxt_st.pll_off = REG_WDATA_IN[PLL_OFF_BIT];
      end

      // break-before-make: finish the old high phase, then wait for the
      // new clock to be low so the first pulse out is a whole one
      unique case (st_ff.sw)
         CCM_SW_RUN: begin
            nxt_st.ref_out = ref_cur;
            if (st_ff.ref_select != st_ff.cur_sel) begin
               nxt_st.sw = CCM_SW_DRAIN;
            end
         end
         CCM_SW_DRAIN: begin
            nxt_st.ref_out = ref_cur;
            if (!ref_cur) begin
               nxt_st.cur_sel = st_ff.ref_select;
               nxt_st.sw      = CCM_SW_ARM;
               nxt_st.ref_out = 1'h0;
            end
         end
         CCM_SW_ARM: begin
            nxt_st.ref_out = 1'h0;
            if (!ref_cur) begin
               nxt_st.sw = CCM_SW_RUN;
            end
         end
         // fourth code of the two-bit state is unused; recover quietly low
         default: begin
            nxt_st.sw      = CCM_SW_RUN;
            nxt_st.ref_out = 1'h0;
         end
      endcase

      nxt_st.sys_out = st_ff.src_ext ? st_ff.ref_out : pll_quarter;

      nxt_st.rvalid = REG_RD_IN;
      nxt_st.rdata  = 16'h0000;
      if (REG_RD_IN) begin
         unique case (REG_ADDR_IN)
            CLOCK_MUX_AND_DIVIDER_ADDR: nxt_st.rdata =
               {1'h0, st_ff.post_ext, st_ff.src_ext, 4'h0,
                st_ff.second_dbl, st_ff.first_dbl, st_ff.ref_select};
            PLL_CONFIG_AND_PAGER_ADDR: nxt_st.rdata =
               {st_ff.n_code, st_ff.low_range, st_ff.sdm_en,
                st_ff.prediv_en, st_ff.prediv_val, 1'h0, st_ff.page,
                st_ff.slot[st_ff.page]};
            POWER_CLOCK_ADDR: nxt_st.rdata = {2'h0, st_ff.clk_off, 13'h0000};
            POWER_PLL_ADDR:   nxt_st.rdata = {6'h00, st_ff.pll_off, 9'h000};
            default:          nxt_st.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESETN_IN) begin
         st_ff         <= '0;
         st_ff.sw      <= CCM_SW_RUN;
         st_ff.src_ext <= SOURCE_SEL_RST;
         st_ff.clk_off <= CLOCK_OFF_RST;
         st_ff.pll_off <= PLL_OFF_RST;
      end else if (CLK_EN_IN) begin
         st_ff <= nxt_st;
      end
   end

   // pll input predivider; held still while the pll is powered down
   ccm_edge_divider u_prediv (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESETN_IN),
      .ce_in    (CLK_EN_IN),
      .ena_in   (!st_ff.pll_off),
      .src_in   (st_ff.ref_out),
      .ratio_in (prediv_ratio),
      .div_out  (PLL_REF_CLOCK_OUT)
   );

   ccm_edge_divider u_pll_post (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESETN_IN),
      .ce_in    (CLK_EN_IN),
      .ena_in   (!st_ff.pll_off),
      .src_in   (st_ff.sync2[2]),
      .ratio_in (PLL_POST_RATIO),
      .div_out  (pll_quarter)
   );

   ccm_edge_divider u_bit_clk (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESETN_IN),
      .ce_in    (CLK_EN_IN),
      .ena_in   (1'h1),
      .src_in   (st_ff.sys_out),
      .ratio_in (BIT_CLK_RATIO),
      .div_out  (BIT_CLOCK_OUT)
   );

   // hi-fi and voice clocks stop with internal clocks off; the bit clock stays up, so registers stay reachable
   ccm_edge_divider u_hifi (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESETN_IN),
      .ce_in    (CLK_EN_IN),
      .ena_in   (!st_ff.clk_off),
      .src_in   (st_ff.sys_out),
      .ratio_in (hifi_ratio),
      .div_out  (HIFI_CLOCK_OUT)
   );

   ccm_edge_divider u_voice (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESETN_IN),
      .ce_in    (CLK_EN_IN),
      .ena_in   (!st_ff.clk_off),
      .src_in   (st_ff.sys_out),
      .ratio_in (voice_ratio),
      .div_out  (VOICE_CLOCK_OUT)
   );

   assign SYSTEM_CLOCK_OUT   = st_ff.sys_out;
   assign REG_RDATA_OUT      = st_ff.rdata;
   assign REG_RVALID_OUT     = st_ff.rvalid;
   assign PLL_PREDIV_OUT     = prediv_ratio[2:0];
   assign PLL_N_DIV_OUT      = (st_ff.n_code < N_MIN_CODE) ? N_ONE
                               : st_ff.n_code;
   assign PLL_FB_DIV_OUT     = st_ff.low_range
                               ? ({2'h0, PLL_N_DIV_OUT} << LF_FB_SHIFT)
                               : {2'h0, PLL_N_DIV_OUT};
   assign PLL_LOW_RANGE_OUT  = st_ff.low_range;
   assign PLL_SDM_EN_OUT     = st_ff.sdm_en;
   assign PLL_FRAC_OUT       = {st_ff.slot[5][1:0], st_ff.slot[4],
                                st_ff.slot[3], st_ff.slot[2], st_ff.slot[1],
                                st_ff.slot[0]};
   assign PLL_POWER_DOWN_OUT = st_ff.pll_off;
   assign INT_CLOCKS_ON_OUT  = !st_ff.clk_off;

   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESETN_IN);

   ref_follow_a: assert property (
      (CLK_EN_IN && st_ff.sw == CCM_SW_RUN && !st_ff.cur_sel &&
       st_ff.ref_select == st_ff.cur_sel) |=>
      (st_ff.ref_out == $past(ref_first)))
      else $error("selected output does not follow first reference");
   doubler_off_a: assert property (
      (CLK_EN_IN && st_ff.sw == CCM_SW_RUN && st_ff.cur_sel &&
       st_ff.ref_select && !st_ff.second_dbl) |=>
      (st_ff.ref_out == $past(st_ff.sync2[1])))
      else $error("second doubler active while disabled");
   prediv_write_a: assert property (
      (CLK_EN_IN && wr_pll && !REG_WDATA_IN[PREDIV_EN_BIT]) |=>
      (PLL_PREDIV_OUT == 3'h1))
      else $error("predivider not bypassed");
   low_range_a: assert property (
      PLL_LOW_RANGE_OUT |-> (PLL_FB_DIV_OUT == {PLL_N_DIV_OUT, 2'h0}))
      else $error("feedback divide by four missing");
   n_floor_a: assert property (
      (CLK_EN_IN && wr_pll && REG_WDATA_IN[15:12] == 4'h0) |=>
      (PLL_N_DIV_OUT == 4'h1))
      else $error("divisor code zero not divide by one");
   sdm_enable_a: assert property (
      (CLK_EN_IN && wr_pll) |=>
      (PLL_SDM_EN_OUT == $past(REG_WDATA_IN[SIGMA_DELTA_BIT])))
      else $error("sigma-delta enable not taken");
   page_store_a: assert property (
      (CLK_EN_IN && wr_pll && REG_WDATA_IN[6:4] == 3'h2) |=>
      (st_ff.slot[2] == $past(REG_WDATA_IN[3:0])))
      else $error("page nibble not stored");
   page_keep_a: assert property (
      (CLK_EN_IN && wr_pll && REG_WDATA_IN[6:4] != 3'h0) |=>
      $stable(st_ff.slot[0]))
      else $error("unaddressed page slot changed");
   clocks_off_a: assert property (
      (st_ff.clk_off && $past(st_ff.clk_off)) |-> (!HIFI_CLOCK_OUT &&
      !VOICE_CLOCK_OUT))
      else $error("internal clocks run while disabled");
   pll_down_a: assert property (
      (CLK_EN_IN && st_ff.pll_off) |=> (!pll_quarter && !PLL_REF_CLOCK_OUT))
      else $error("pll path active while powered down");
   switch_gap_a: assert property (
      $changed(st_ff.cur_sel) |-> !st_ff.ref_out ##1 (!st_ff.ref_out ||
      st_ff.sw == CCM_SW_RUN))
      else $error("reference switch produced a pulse fragment");

   switch_second_c: cover property (
      $changed(st_ff.cur_sel) && st_ff.cur_sel);
   sdm_on_c: cover property (PLL_SDM_EN_OUT && !PLL_POWER_DOWN_OUT);
   pll_source_c: cover property (!st_ff.src_ext && $rose(SYSTEM_CLOCK_OUT));

endmodule

// >>> shared/ccm_pkg.sv
// codec clock mux and pll control: register map, field positions, constants
// assumes 7-bit register indices and 16-bit register words
package ccm_pkg;

   // register indices
   localparam logic [6:0] CLOCK_MUX_AND_DIVIDER_ADDR = 7'h44;
   localparam logic [6:0] PLL_CONFIG_AND_PAGER_ADDR  = 7'h46;
   localparam logic [6:0] POWER_CLOCK_ADDR           = 7'h26;
   localparam logic [6:0] POWER_PLL_ADDR             = 7'h3C;

   // clock_mux_and_divider fields
   localparam int REF_SELECT_BIT   = 0;
   localparam int FIRST_DBL_BIT    = 1;
   localparam int SECOND_DBL_BIT   = 2;
   localparam int SOURCE_SEL_BIT   = 7;
   localparam int POST_DIV_LSB     = 8;
   localparam int POST_DIV_W       = 7;

   // pll_config_and_pager fields
   localparam int N_CODE_LSB       = 12;
   localparam int LOW_RANGE_BIT    = 11;
   localparam int SIGMA_DELTA_BIT  = 10;
   localparam int PREDIV_EN_BIT    = 9;
   localparam int PREDIV_VAL_BIT   = 8;
   localparam int PAGE_SEL_LSB     = 4;
   localparam int PAGE_NIBBLE_LSB  = 0;

   // power register fields
   localparam int CLOCK_OFF_BIT    = 13;
   localparam int PLL_OFF_BIT      = 9;

   // pages
   localparam logic [2:0] PAGE_POST_HI  = 3'h7;
   localparam logic [2:0] PAGE_POST_LO  = 3'h6;
   localparam logic [2:0] PAGE_FRAC_TOP = 3'h5;
   localparam logic [3:0] POST_HI_MASK  = 4'h7;
   localparam logic [3:0] FRAC_TOP_MASK = 4'h3;

   // reset values
   localparam logic SOURCE_SEL_RST = 1'h1;
   localparam logic CLOCK_OFF_RST  = 1'h1;
   localparam logic PLL_OFF_RST    = 1'h1;

   // fixed division ratios
   localparam logic [4:0] PLL_POST_RATIO  = 5'h04;
   localparam logic [4:0] BIT_CLK_RATIO   = 5'h02;
   localparam logic [4:0] PREDIV_OFF      = 5'h01;
   localparam logic [4:0] PREDIV_HALF     = 5'h02;
   localparam logic [4:0] PREDIV_QUARTER  = 5'h04;
   localparam logic [3:0] N_MIN_CODE      = 4'h2;
   localparam logic [3:0] N_ONE           = 4'h1;
   localparam int         LF_FB_SHIFT     = 2;

   typedef enum logic [1:0] {CCM_SW_RUN, CCM_SW_DRAIN, CCM_SW_ARM} ccm_sw_t;

   // divide-by value of a ratio field: code k divides by k+1
   function automatic logic [4:0] ccm_ratio(input logic [3:0] field);
      return {1'h0, field} + 5'h01;
   endfunction

endpackage

// >>> rtl/ccm_edge_divider.sv
// sampled-clock divider: counts rising edges of a clock level
// assumes src_in is already synchronous to clk_in
`timescale 1ns/1ps
module ccm_edge_divider
   import ccm_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   input  wire logic       ena_in,
   input  wire logic       src_in,
   input  wire logic [4:0] ratio_in,
   output logic            div_out
);

   typedef struct packed {
      logic       prev;
      logic [3:0] cnt;
      logic       out;
   } ccm_div_state_t;

   ccm_div_state_t st_ff;
   ccm_div_state_t nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.prev = src_in;
      if (!ena_in) begin
         // held low and restarted so it resumes on a clean phase
         nxt_st.cnt = 4'h0;
         nxt_st.out = 1'h0;
      end else begin
         if (src_in && !st_ff.prev) begin
            if (({1'h0, st_ff.cnt} + 5'h01) >= ratio_in) begin
               nxt_st.cnt = 4'h0;
            end else begin
               nxt_st.cnt = st_ff.cnt + 4'h1;
            end
         end
         if (ratio_in <= 5'h01) begin
            nxt_st.out = src_in;
         end else begin
            nxt_st.out = ({1'h0, nxt_st.cnt} < (ratio_in >> 1));
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_ff <= '0;
      end else if (ce_in) begin
         st_ff <= nxt_st;
      end
   end

   assign div_out = st_ff.out;

endmodule

// >>> tb/ccm_ref_clocks.sv
// reference clock sources: two references and the returned pll output
// assumes the bench only observes these clocks and never drives them
`timescale 1ns/1ps
module ccm_ref_clocks
#(
   parameter int FIRST_HALF_NS  = 800,
   parameter int SECOND_HALF_NS = 1200,
   parameter int PLL_HALF_NS    = 300
)
(
   output logic first_ref_out,
   output logic second_ref_out,
   output logic pll_out
);
   // first reference free-runs from time zero and never stops, so it is
   // there at power-up and still toggling long after a switch away
   initial first_ref_out = 1'b0;
   initial second_ref_out = 1'b0;
   initial pll_out = 1'b0;
   always #(FIRST_HALF_NS) first_ref_out = ~first_ref_out;
   // odd start offset keeps the second source out of phase with the first
   initial begin
      #137;
      forever #(SECOND_HALF_NS) second_ref_out = ~second_ref_out;
   end
   always #(PLL_HALF_NS) pll_out = ~pll_out;
endmodule

// >>> tb/testbench.sv
// register-level bench for the codec clock mux and pll control
// assumes ccm_pkg is compiled first and ccm_ref_clocks supplies the pins
`timescale 1ns/1ps
module testbench
   import ccm_pkg::*;
;
   localparam int WIN = 960;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        clk_en = 1'b1;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic [6:0]  addr = 7'h00;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic        rvalid, sys_clk, bit_clk, hifi_clk, voice_clk, pll_ref;
   logic [2:0]  prediv;
   logic [3:0]  n_div;
   logic [5:0]  fb_div;
   logic        low_range, sdm_en, pll_down, clocks_on;
   logic [21:0] frac;
   logic        ref_a, ref_b, pll_clk;
   logic [4:0]  mon;
   logic [4:0]  prev = 5'h00;
   int          fails = 0;
   int          num_checks = 0;
   int          cnt [5] = '{default: 0};
   int          d [5];
   int          run = 0;
   int          min_run = 1000;

   always #50 clk = ~clk;
   assign mon = {pll_ref, voice_clk, hifi_clk, bit_clk, sys_clk};

   ccm_ref_clocks refs (
      .first_ref_out  (ref_a),
      .second_ref_out (ref_b),
      .pll_out        (pll_clk)
   );

   ccm_clock_control DUT (
      .CORE_CLK_IN         (clk),
      .RESETN_IN           (rst_n),
      .CLK_EN_IN           (clk_en),
      .FIRST_REF_CLOCK_IN  (ref_a),
      .SECOND_REF_CLOCK_IN (ref_b),
      .PLL_OUT_CLOCK_IN    (pll_clk),
      .REG_WR_IN           (wr_s),
      .REG_RD_IN           (rd_s),
      .REG_ADDR_IN         (addr),
      .REG_WDATA_IN        (wdata),
      .REG_RDATA_OUT       (rdata),
      .REG_RVALID_OUT      (rvalid),
      .SYSTEM_CLOCK_OUT    (sys_clk),
      .BIT_CLOCK_OUT       (bit_clk),
      .HIFI_CLOCK_OUT      (hifi_clk),
      .VOICE_CLOCK_OUT     (voice_clk),
      .PLL_REF_CLOCK_OUT   (pll_ref),
      .PLL_PREDIV_OUT      (prediv),
      .PLL_N_DIV_OUT       (n_div),
      .PLL_FB_DIV_OUT      (fb_div),
      .PLL_LOW_RANGE_OUT   (low_range),
      .PLL_SDM_EN_OUT      (sdm_en),
      .PLL_FRAC_OUT        (frac),
      .PLL_POWER_DOWN_OUT  (pll_down),
      .INT_CLOCKS_ON_OUT   (clocks_on)
   );

   // edge counters and shortest system clock high run, in core samples
   always @(negedge clk) begin
      prev <= mon;
      for (int i = 0; i < 5; i++) begin
         if (mon[i] && !prev[i]) cnt[i] <= cnt[i] + 1;
      end
      run <= sys_clk ? run + 1 : 0;
      if (prev[0] && !sys_clk && run < min_run) min_run <= run;
   end

   task automatic summarize();
      if (fails == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // edge counts drift by an edge or two with async phase and switch drain
   task automatic near(input int got, input int exp);
      num_checks++;
      if (got < exp - 2 || got > exp + 2) begin
         fails++;
         $display("Error at %0t: %0d edges, expected %0d", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      @(negedge clk);
      wr_s = 1'b1;
      addr = a;
      wdata = v;
      @(negedge clk);
      wr_s = 1'b0;
   endtask

   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      @(negedge clk);
      rd_s = 1'b1;
      addr = a;
      @(negedge clk);
      rd_s = 1'b0;
      check(rvalid, 1'b1);
      check(rdata, exp);
   endtask

   task automatic measure();
      int s [5];
      @(negedge clk);
      s = cnt;
      repeat (WIN) @(negedge clk);
      foreach (d[i]) d[i] = cnt[i] - s[i];
   endtask

   initial begin
      #3_000_000;
      fails++;
      summarize();
   end

   initial begin
      logic [3:0] c;
      logic [3:0] q;
      int         e;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      check(pll_down, 1'b1);
      check(clocks_on, 1'b0);
      check({prediv, n_div, fb_div}, {3'h1, 4'h1, 6'h01});
      check({low_range, sdm_en, frac}, 24'h000000);
      rd(CLOCK_MUX_AND_DIVIDER_ADDR, 16'h0080);
      rd(PLL_CONFIG_AND_PAGER_ADDR, 16'h0000);
      rd(POWER_CLOCK_ADDR, 16'h2000);
      rd(POWER_PLL_ADDR, 16'h0200);
      rd(7'h10, 16'h0000);
      wr(CLOCK_MUX_AND_DIVIDER_ADDR, 16'hFFFF);
      rd(CLOCK_MUX_AND_DIVIDER_ADDR, 16'h7F87);
      wr(CLOCK_MUX_AND_DIVIDER_ADDR, 16'h3180);
      measure();
      near(d[0], 60);
      near(d[1], 30);
      near(d[2] + d[3] + d[4], 0);
      wr(POWER_CLOCK_ADDR, 16'h0000);
      check(clocks_on, 1'b1);
      measure();
      near(d[2], 15);
      near(d[3], 30);
      min_run = 1000;
      wr(CLOCK_MUX_AND_DIVIDER_ADDR, 16'h3181);
      measure();
      near(d[0], 40);
      near(d[1], 20);
      check(min_run >= 6, 1'b1);
      wr(CLOCK_MUX_AND_DIVIDER_ADDR, 16'h3185);
      measure();
      near(d[0], 80);
      wr(CLOCK_MUX_AND_DIVIDER_ADDR, 16'h3182);
      measure();
      near(d[0], 120);
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         e = (i < 2) ? 1 : i;
         // modulator on whenever the code lies outside the integer range
         q = {c[3], (i < 5 || i > 12), c[1:0]};
         wr(PLL_CONFIG_AND_PAGER_ADDR, {c, q, 8'h08});
         check(n_div, e);
         check(fb_div, q[3] ? e * 4 : e);
         check({low_range, sdm_en}, q[3:2]);
         check(prediv, !q[1] ? 1 : (q[0] ? 4 : 2));
         rd(PLL_CONFIG_AND_PAGER_ADDR, {c, q, 8'h08});
      end
      // integer divisor 7 keeps the loop inside its integer-mode range
      for (int p = 0; p < 8; p++) begin
         wr(PLL_CONFIG_AND_PAGER_ADDR, 16'h7000 | 16'(p * 17 + 8));
      end
      check(frac, 22'h1CBA98);
      rd(PLL_CONFIG_AND_PAGER_ADDR, 16'h7077);
      wr(PLL_CONFIG_AND_PAGER_ADDR, 16'h7023);
      check(frac, 22'h1CB398);
      rd(PLL_CONFIG_AND_PAGER_ADDR, 16'h7023);
      wr(PLL_CONFIG_AND_PAGER_ADDR, 16'h7071);
      wr(PLL_CONFIG_AND_PAGER_ADDR, 16'h7063);
      check(frac, 22'h1CB398);
      wr(POWER_PLL_ADDR, 16'h0000);
      check(pll_down, 1'b0);
      wr(PLL_CONFIG_AND_PAGER_ADDR, 16'h7223);
      wr(CLOCK_MUX_AND_DIVIDER_ADDR, 16'h3100);
      measure();
      near(d[0], 40);
      near(d[1], 20);
      near(d[2], 20);
      near(d[3], 10);
      near(d[4], 30);
      // with the enable low nothing may be taken
      @(negedge clk);
      clk_en = 1'b0;
      wr(POWER_CLOCK_ADDR, 16'h2000);
      clk_en = 1'b1;
      check(clocks_on, 1'b1);
      wr(POWER_CLOCK_ADDR, 16'h2000);
      check(clocks_on, 1'b0);
      summarize();
   end
endmodule
